//--- shared/sea_pkg.sv
// Purpose: constants and types for the safety error aggregator
// Assumes: 32-bit plain register port, one clock, async active-low reset
// Notes:   error sources are level-free one-cycle event pulses
package sea_pkg;
    localparam int NUM_ERR = 16;
    localparam int ADDR_W  = 4;

    localparam logic [ADDR_W-1:0] OFS_VERSION = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_PENDING = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_ENABLE  = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_STATUS  = 4'hC;

    localparam int VER_MAJ_LSB = 16;
    localparam int VER_MIN_LSB = 8;
    localparam int VER_IMP_LSB = 0;
    // version values are arbitrary
    localparam logic [7:0] VERSION_MAJOR          = 8'h01;
    localparam logic [7:0] VERSION_MINOR          = 8'h00;
    localparam logic [7:0] VERSION_IMPLEMENTATION = 8'h00;

    localparam logic [NUM_ERR-1:0] ENABLE_RST  = 16'h0000;
    localparam logic [NUM_ERR-1:0] PENDING_RST = 16'h0000;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0]       wdata;
        logic              wr;
        logic              rd;
    } sea_req_t;

    typedef enum logic [1:0] {
        HS_RUN,
        HS_WAIT,
        HS_DONE
    } sea_hs_t;
endpackage

//--- verilog/sea_hs.sv
`timescale 1ns/10ps
// Purpose: clock-stop/reset handshake answering on aggregator idle
// Assumes: request held high until acknowledged, then dropped
// Notes:   ack raised only after a cycle in which idle was high
module sea_hs (
    input  wire logic ref_clk,
    input  wire logic rstn,
    input  wire logic stop_req,
    input  wire logic idle,
    output logic      stop_ack
);
    import sea_pkg::*;
    sea_hs_t state_q;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= HS_RUN;
        end else begin
            case (state_q)
                HS_RUN:  if (stop_req) state_q <= HS_WAIT;
                // may stall forever while errors stay pending
                HS_WAIT: begin
                    if (!stop_req) state_q <= HS_RUN;
                    else if (idle) state_q <= HS_DONE;
                end
                HS_DONE: if (!stop_req) state_q <= HS_RUN;
                default: state_q <= HS_RUN;
            endcase
        end
    end

    assign stop_ack = (state_q == HS_DONE);

    a_ack_needs_idle: assert property (@(posedge ref_clk) disable iff (!rstn)
        $rose(stop_ack) |-> $past(idle))
        else $error("ack raised without idle");
endmodule

//--- verilog/sea_top.sv
// The plain strobed port was chosen for this implementation.
`timescale 1ns/10ps
// Purpose: safety error aggregator with per-error enable and clear
// Assumes: reads return data the cycle after the read strobe
// Notes:   pending writes are write-one-to-clear; set beats clear
module sea_top (
    input  wire logic                 ref_clk,
    input  wire logic                 rstn,
    input  wire sea_pkg::sea_req_t    req,
    output logic [31:0]               rdata,
    input  wire logic [sea_pkg::NUM_ERR-1:0] err_event,
    output logic                      irq,
    output logic                      idle,
    input  wire logic                 stop_req,
    output logic                      stop_ack
);
    import sea_pkg::*;

    logic [NUM_ERR-1:0] pending_q;
    logic [NUM_ERR-1:0] enable_q;
    logic [31:0]        rdata_q;

    function automatic logic hit(input logic [ADDR_W-1:0] ofs);
        return req.addr == ofs;
    endfunction

    // pending latches even when disabled, so idle reflects all errors
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pending_q <= PENDING_RST;
        end else begin
            pending_q <= (pending_q & ~((req.wr && hit(OFS_PENDING))
                         ? req.wdata[NUM_ERR-1:0] : '0))
                         | err_event;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            enable_q <= ENABLE_RST;
        end else if (req.wr && hit(OFS_ENABLE)) begin
            enable_q <= req.wdata[NUM_ERR-1:0];
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= '0;
        end else if (req.rd) begin
            case (req.addr)
                OFS_VERSION: rdata_q <= {8'h00,
                    VERSION_MAJOR, VERSION_MINOR,
                    VERSION_IMPLEMENTATION};
                OFS_PENDING: rdata_q <= 32'(pending_q);
                OFS_ENABLE:  rdata_q <= 32'(enable_q);
                OFS_STATUS:  rdata_q <= {30'h0, stop_ack, idle};
                default:     rdata_q <= '0;
            endcase
        end else begin
            rdata_q <= '0;
        end
    end

    assign rdata = rdata_q;
    assign irq   = |(pending_q & enable_q);
    assign idle  = ~|pending_q;

    sea_hs u_hs (
        .ref_clk  (ref_clk),
        .rstn     (rstn),
        .stop_req (stop_req),
        .idle     (idle),
        .stop_ack (stop_ack)
    );

    a_event_pends: assert property (@(posedge ref_clk) disable iff (!rstn)
        |err_event |=> |pending_q)
        else $error("event not pending");
    a_idle_masked: assert property (@(posedge ref_clk) disable iff (!rstn)
        (|pending_q && enable_q == '0) |-> !idle)
        else $error("idle with masked pending");
    a_idle_back: assert property (@(posedge ref_clk) disable iff (!rstn)
        (req.wr && hit(OFS_PENDING) && req.wdata[NUM_ERR-1:0] == '1
         && err_event == '0) |=> idle)
        else $error("idle not restored");
    a_irq_enable: assert property (@(posedge ref_clk) disable iff (!rstn)
        irq |-> |(pending_q & enable_q))
        else $error("irq without enabled pending");
    a_version_rd: assert property (@(posedge ref_clk) disable iff (!rstn)
        (req.rd && req.addr == OFS_VERSION) |=>
        rdata[VER_MAJ_LSB+:8] == VERSION_MAJOR
        && rdata[VER_MIN_LSB+:8] == VERSION_MINOR
        && rdata[VER_IMP_LSB+:8] == VERSION_IMPLEMENTATION)
        else $error("bad version read");
    // a write to the version word, then a read within four cycles
    a_version_ro: assert property (@(posedge ref_clk) disable iff (!rstn)
        (req.wr && req.addr == OFS_VERSION) ##[1:4] (req.rd
        && req.addr == OFS_VERSION) |=>
        rdata[VER_MAJ_LSB+:8] == VERSION_MAJOR
        && rdata[VER_MIN_LSB+:8] == VERSION_MINOR
        && rdata[VER_IMP_LSB+:8] == VERSION_IMPLEMENTATION)
        else $error("version writable");
    a_stall_pend: assert property (@(posedge ref_clk) disable iff (!rstn)
        (stop_req && !stop_ack && |pending_q) |=> !stop_ack)
        else $error("ack while pending");
    a_set_wins: assert property (@(posedge ref_clk) disable iff (!rstn)
        (err_event[0] && req.wr && hit(OFS_PENDING) && req.wdata[0])
        |=> pending_q[0])
        else $error("clear beat set");

    // read data stands only in the cycle after the read strobe
    a_rdata_quiet: assert property (@(posedge ref_clk) disable iff (!rstn)
        !req.rd |=> rdata == '0)
        else $error("read data outside read");
    a_irq_raised: assert property (@(posedge ref_clk) disable iff (!rstn)
        |(pending_q & enable_q) |-> irq)
        else $error("enabled pending without irq");
    a_idle_clear: assert property (@(posedge ref_clk) disable iff (!rstn)
        (pending_q == '0) |-> idle)
        else $error("idle low with nothing pending");
    // a pending bit only leaves through a software clear
    a_pend_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
        !(req.wr && hit(OFS_PENDING)) |=>
        (pending_q & $past(pending_q)) == $past(pending_q))
        else $error("pending lost without clear");
    a_enable_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
        !(req.wr && hit(OFS_ENABLE)) |=> $stable(enable_q))
        else $error("enable changed without write");
    a_status_rd: assert property (@(posedge ref_clk) disable iff (!rstn)
        (req.rd && req.addr == OFS_STATUS) |=>
        rdata[0] == $past(idle))
        else $error("bad status read");
endmodule

//--- test/sea_far.sv
`timescale 1ns/10ps
// Purpose: error injector and stop controller
// Assumes: inj is held for one cycle
// Notes:   request held until ack
module sea_far (
    input  wire logic        ref_clk,
    input  wire logic [15:0] inj,
    input  wire logic        go,
    input  wire logic        stop_ack,
    output logic [15:0]      err_event,
    output logic             stop_req
);
    initial stop_req = 1'b0;
    assign err_event = inj;
    // released the cycle after ack
    always @(posedge ref_clk) begin
        stop_req <= !stop_ack && (go || stop_req);
    end
endmodule

//--- test/safety_error_aggregator_test.sv
`timescale 1ns/10ps
// Purpose: self-checking bench for the aggregator
// Assumes: sea_far drives errors and stop requests
// Notes:   model keeps pending and enable vectors
module safety_error_aggregator_test;
    import sea_pkg::*;
    logic        ref_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        go = 1'b0;
    logic [15:0] inj = 16'h0000;
    logic [15:0] err_event;
    logic [31:0] rdata, got, ver;
    logic        irq, idle, stop_req, stop_ack;
    sea_req_t    req = '0;
    bit   [15:0] pend, en, v;
    int          error_cnt, check_count;
    always #2 ref_clk = ~ref_clk;
    sea_top u_sea_top (.ref_clk, .rstn, .req, .rdata, .err_event,
        .irq, .idle, .stop_req, .stop_ack);
    sea_far u_sea_far (.ref_clk, .inj, .go, .stop_ack, .err_event,
        .stop_req);
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic wr(logic [3:0] a, logic [31:0] d);
        @(posedge ref_clk) req <= '{a, d, 1'b1, 1'b0};
        @(posedge ref_clk) req <= '0;
        #1;
        if (a == OFS_PENDING) pend &= ~d[15:0];
        if (a == OFS_ENABLE) en = d[15:0];
    endtask
    task automatic rd(logic [3:0] a);
        @(posedge ref_clk) req <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge ref_clk) req <= '0;
        #1 got = rdata;
    endtask
    task automatic flags();
        chk("irq", {31'h0, |(pend & en)}, {31'h0, irq});
        chk("idle", {31'h0, pend == 16'h0}, {31'h0, idle});
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #4000;
        error_cnt++;
        end_sim();
    end
    initial begin
        void'($urandom(32'h64EC));
        ver = {8'h00, VERSION_MAJOR, VERSION_MINOR, VERSION_IMPLEMENTATION};
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        #1 flags();
        for (int k = 0; k < 2; k++) begin
            rd(OFS_VERSION);
            chk("version", ver, got);
            wr(OFS_VERSION, 32'hFFFFFFFF);
        end
        rd(4'h1);
        chk("unmapped", 32'h0, got);
        @(posedge ref_clk);
        #1 chk("rdata", 32'h0, rdata);
        $display("version test done");
        for (int i = 0; i < 4; i++) begin
            v = 16'($urandom) | 16'h0001;
            wr(OFS_ENABLE, $urandom);
            @(posedge ref_clk) inj <= v;
            @(posedge ref_clk) inj <= 16'h0000;
            #1 pend |= v;
            flags();
            rd(OFS_ENABLE);
            chk("enable", {16'h0, en}, got);
            rd(OFS_PENDING);
            chk("pending", {16'h0, pend}, got);
            wr(OFS_PENDING, $urandom);
            flags();
        end
        @(posedge ref_clk) inj <= 16'h0001;
        req <= '{OFS_PENDING, 32'h00000001, 1'b1, 1'b0};
        @(posedge ref_clk) inj <= 16'h0000;
        req <= '0;
        #1 pend |= 16'h0001;
        rd(OFS_PENDING);
        chk("set wins", {16'h0, pend}, got);
        $display("event test done");
        @(posedge ref_clk) go <= 1'b1;
        inj <= 16'h8000;
        @(posedge ref_clk) go <= 1'b0;
        inj <= 16'h0000;
        pend |= 16'h8000;
        repeat (20) @(posedge ref_clk);
        chk("ack", 32'h0, {31'h0, stop_ack});
        rd(OFS_STATUS);
        chk("status", 32'h0, got);
        wr(OFS_PENDING, 32'h0000FFFF);
        for (int k = 0; k < 4 && stop_ack !== 1'b1; k++) @(posedge ref_clk);
        #1 chk("ack", 32'h1, {31'h0, stop_ack});
        $display("stop test done");
        end_sim();
    end
endmodule
